// ==== logic/alu_defines.vh ====
// Contract
// - signed add to accumulator and accumulator add: one cycle, only accumulator status flags.
// - add with carry sums operands plus carry in one cycle; five flags updated.
// - shift right by register amount: one cycle, only N and Z updated.
// - single-bit arithmetic shift right: one cycle, carry, sign, overflow, zero updated.
// - signed branches cost one cycle not taken, four taken, flags untouched.
// - unsigned branches cost one cycle not taken, four taken, flags untouched.
// - branches on accumulator A/B overflow and saturation, one or four cycles.
// - branches on carry, sign, overflow, zero and their inverses, one or four cycles.
// - reads or read-modify-write of peripheral registers by opcodes other than add, shift and branch take one extra cycle.
`ifndef ALU_DEFINES_VH
`define ALU_DEFINES_VH
`define OP_ADD_ACC 4'h0
`define OP_ADD_ACCS 4'h1
`define OP_ADD_CARRY 4'h2
`define OP_SHR_REG 4'h3
`define OP_SHR_ONE 4'h4
`define OP_BRANCH 4'h5
`define OP_OTHER 4'h6
`define CC_C 5'h00
`define CC_GE 5'h01
`define CC_GEU 5'h02
`define CC_GT 5'h03
`define CC_GTU 5'h04
`define CC_LE 5'h05
`define CC_LEU 5'h06
`define CC_LT 5'h07
`define CC_LTU 5'h08
`define CC_N 5'h09
`define CC_NC 5'h0a
`define CC_NN 5'h0b
`define CC_NOV 5'h0c
`define CC_NZ 5'h0d
`define CC_ACC_A_OVF 5'h0e
`define CC_ACC_B_OVF 5'h0f
`define CC_OVF 5'h10
`define CC_ACC_A_SAT 5'h11
`define CC_ACC_B_SAT 5'h12
`define CC_Z 5'h13
`define CC_ALWAYS 5'h14
`define TAKEN_STALLS 2'h3
`define ACC_W 40
`define ACC_SIGN 39
`define ACC_OVF_LO 31
`define ACC_MAX 40'h7fffffffff
`define ACC_MIN 40'h8000000000
`define SIGN_BIT 15
`define HALF_BIT 8
`define SHAMT_MASK 16'h000f
`endif

// ==== logic/branch_cond.v ====
`timescale 1ns/1ns
`include "alu_defines.vh"
module branch_cond (
  // condition select
  input wire [4:0] cond,
  // flags
  input wire c,
  input wire n,
  input wire ovf,
  input wire z,
  input wire a_ovf,
  input wire b_ovf,
  input wire a_sat,
  input wire b_sat,
  // result
  output reg taken
);
  always @* begin
    case (cond)
      `CC_C: taken = c;
      `CC_NC: taken = ~c;
      `CC_N: taken = n;
      `CC_NN: taken = ~n;
      `CC_OVF: taken = ovf;
      `CC_NOV: taken = ~ovf;
      `CC_Z: taken = z;
      `CC_NZ: taken = ~z;
      `CC_GE: taken = ~(n ^ ovf);
      `CC_GT: taken = ~z & ~(n ^ ovf);
      `CC_LE: taken = z | (n ^ ovf);
      `CC_LT: taken = n ^ ovf;
      `CC_GEU: taken = c;
      `CC_GTU: taken = c & ~z;
      `CC_LEU: taken = ~c | z;
      `CC_LTU: taken = ~c;
      `CC_ACC_A_OVF: taken = a_ovf;
      `CC_ACC_B_OVF: taken = b_ovf;
      `CC_ACC_A_SAT: taken = a_sat;
      `CC_ACC_B_SAT: taken = b_sat;
      `CC_ALWAYS: taken = 1'b1;
      default: taken = 1'b0;
    endcase
  end
endmodule

// ==== logic/cpu_arith_branch_subset.v ====
`timescale 1ns/1ns
`include "alu_defines.vh"
module cpu_arith_branch_subset (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // instruction issue from decode
  input wire issue_valid,
  input wire [3:0] opcode,
  input wire [4:0] cond,
  input wire acc_sel,
  input wire periph_access,
  input wire [15:0] operand_a,
  input wire [15:0] operand_b,
  // accumulator inputs from register file
  input wire [39:0] acc_a_in,
  input wire [39:0] acc_b_in,
  // issue handshake
  output wire issue_ready,
  // results
  output reg result_valid,
  output reg [15:0] result,
  output reg [39:0] acc_result,
  output reg acc_result_valid,
  output reg acc_result_sel,
  output reg branch_taken,
  output wire flush,
  // status flags
  output reg carry_flag,
  output reg half_carry_flag,
  output reg negative_flag,
  output reg overflow_flag,
  output reg zero_flag,
  output reg acc_a_overflow_flag,
  output reg acc_b_overflow_flag,
  output reg acc_a_saturated_flag,
  output reg acc_b_saturated_flag
);
  localparam ST_RUN = 3'b001;
  localparam ST_FLUSH = 3'b010;
  localparam ST_PERIPH = 3'b100;

  reg [2:0] state_q;
  reg [1:0] stall_cnt_q;
  wire cond_taken;
  wire accept;
  wire [16:0] carry_sum;
  wire [8:0] carry_low;
  wire signed [15:0] a_s;
  wire [15:0] shr_reg_val;
  wire [15:0] shr_one_val;
  wire [39:0] acc_src;
  wire [39:0] acc_addend;
  wire [40:0] acc_sum;
  wire acc_ovf;
  wire acc_sat;
  wire [39:0] acc_final;

  branch_cond branch_cond_i (
    .cond(cond),
    .c(carry_flag),
    .n(negative_flag),
    .ovf(overflow_flag),
    .z(zero_flag),
    .a_ovf(acc_a_overflow_flag),
    .b_ovf(acc_b_overflow_flag),
    .a_sat(acc_a_saturated_flag),
    .b_sat(acc_b_saturated_flag),
    .taken(cond_taken)
  );

  // decoder must hold its instruction while stalled
  assign issue_ready = state_q[0];
  assign accept = issue_valid & issue_ready;
  assign flush = state_q[1];

  assign carry_sum = {1'b0, operand_a} + {1'b0, operand_b} + {16'h0000, carry_flag};
  assign carry_low = {1'b0, operand_a[7:0]} + {1'b0, operand_b[7:0]} + {8'h00, carry_flag};
  assign a_s = operand_a;
  assign shr_reg_val = a_s >>> (operand_b & `SHAMT_MASK);
  assign shr_one_val = {operand_a[`SIGN_BIT], operand_a[15:1]};

  // signed word into accumulator, or other accumulator
  assign acc_src = acc_sel ? acc_b_in : acc_a_in;
  assign acc_addend = (opcode == `OP_ADD_ACCS) ? (acc_sel ? acc_a_in : acc_b_in)
                                               : {{24{operand_a[15]}}, operand_a};
  assign acc_sum = {acc_src[`ACC_SIGN], acc_src} + {acc_addend[`ACC_SIGN], acc_addend};
  assign acc_sat = acc_sum[40] ^ acc_sum[`ACC_SIGN];
  // overflow into guard bits beyond the 32-bit field
  assign acc_ovf = |(acc_sum[39:`ACC_OVF_LO] ^ {9{acc_sum[`ACC_SIGN]}});
  // saturate rather than wrap, clamping to ACC_MAX or ACC_MIN by the true sign
  assign acc_final = acc_sat ? (acc_sum[40] ? `ACC_MIN : `ACC_MAX) : acc_sum[39:0];

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_RUN;
      stall_cnt_q <= 2'h0;
      result_valid <= 1'b0;
      result <= 16'h0000;
      acc_result <= 40'h0000000000;
      acc_result_valid <= 1'b0;
      acc_result_sel <= 1'b0;
      branch_taken <= 1'b0;
      carry_flag <= 1'b0;
      half_carry_flag <= 1'b0;
      negative_flag <= 1'b0;
      overflow_flag <= 1'b0;
      zero_flag <= 1'b0;
      acc_a_overflow_flag <= 1'b0;
      acc_b_overflow_flag <= 1'b0;
      acc_a_saturated_flag <= 1'b0;
      acc_b_saturated_flag <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      acc_result_valid <= 1'b0;
      branch_taken <= 1'b0;
      case (state_q)
        ST_RUN: begin
          if (accept) begin
            // each op writes only its own flags
            case (opcode)
              `OP_ADD_ACC, `OP_ADD_ACCS: begin
                acc_result <= acc_final;
                acc_result_sel <= acc_sel;
                acc_result_valid <= 1'b1;
                if (acc_sel) begin
                  acc_b_overflow_flag <= acc_ovf;
                  acc_b_saturated_flag <= acc_b_saturated_flag | acc_sat;
                end else begin
                  acc_a_overflow_flag <= acc_ovf;
                  acc_a_saturated_flag <= acc_a_saturated_flag | acc_sat;
                end
              end
              `OP_ADD_CARRY: begin
                result <= carry_sum[15:0];
                result_valid <= 1'b1;
                carry_flag <= carry_sum[16];
                half_carry_flag <= carry_low[`HALF_BIT];
                negative_flag <= carry_sum[`SIGN_BIT];
                overflow_flag <= (operand_a[15] == operand_b[15]) & (carry_sum[15] != operand_a[15]);
                // sticky zero lets multi-word sums chain
                zero_flag <= zero_flag & (carry_sum[15:0] == 16'h0000);
              end
              `OP_SHR_REG: begin
                result <= shr_reg_val;
                result_valid <= 1'b1;
                negative_flag <= shr_reg_val[`SIGN_BIT];
                zero_flag <= (shr_reg_val == 16'h0000);
              end
              `OP_SHR_ONE: begin
                result <= shr_one_val;
                result_valid <= 1'b1;
                carry_flag <= operand_a[0];
                negative_flag <= shr_one_val[`SIGN_BIT];
                overflow_flag <= 1'b0;
                zero_flag <= (shr_one_val == 16'h0000);
              end
              `OP_BRANCH: begin
                if (cond_taken) begin
                  branch_taken <= 1'b1;
                  state_q <= ST_FLUSH;
                  stall_cnt_q <= `TAKEN_STALLS;
                end
              end
              default: begin
                if (periph_access) begin
                  state_q <= ST_PERIPH;
                end
              end
            endcase
          end
        end
        ST_FLUSH: begin
          if (stall_cnt_q == 2'h1) begin
            state_q <= ST_RUN;
          end
          stall_cnt_q <= stall_cnt_q - 2'h1;
        end
        ST_PERIPH: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end
endmodule

// ==== sim/cpu_arith_branch_subset_asserts.sv ====
`timescale 1ns/1ns
`include "alu_defines.vh"
module cpu_arith_branch_subset_asserts (
  input wire clk, reset_n, issue_valid, issue_ready, periph_access, result_valid, branch_taken, flush,
  input wire [3:0] opcode,
  input wire [4:0] cond,
  input wire [15:0] operand_a, operand_b, result,
  input wire carry_flag, half_carry_flag, negative_flag, overflow_flag, zero_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire go = issue_valid && issue_ready;
  wire [4:0] fl = {carry_flag, half_carry_flag, negative_flag, overflow_flag, zero_flag};
  a_carry_sum: assert property (go && opcode == `OP_ADD_CARRY |=> result_valid &&
    {carry_flag, result} == $past({1'b0, operand_a} + operand_b + carry_flag)) else $error("add with carry wrong");
  a_shr_reg_keep: assert property (go && opcode == `OP_SHR_REG |=> $stable({carry_flag, overflow_flag}) &&
    result == $past($signed(operand_a) >>> operand_b[3:0])) else $error("shift by register wrong");
  a_shr_one_flags: assert property (go && opcode == `OP_SHR_ONE |=> result == $past({operand_a[15], operand_a[15:1]})
    && carry_flag == $past(operand_a[0]) && !overflow_flag) else $error("single shift wrong");
  a_branch_keep: assert property (go && opcode == `OP_BRANCH |=> $stable(fl)) else $error("branch moved a flag");
  a_acc_keep: assert property (go && opcode <= `OP_ADD_ACCS |=> $stable(fl)) else $error("acc add moved a flag");
  a_taken_stall: assert property (branch_taken |-> flush [*3] ##1 !flush) else $error("flush length wrong");
  a_flush_block: assert property (flush |-> !issue_ready) else $error("issue during flush");
  a_zero_branch: assert property (go && opcode == `OP_BRANCH && cond == `CC_Z |=>
    branch_taken == $past(zero_flag)) else $error("zero branch wrong");
  a_periph_stall: assert property (go && opcode == `OP_OTHER && periph_access |=>
    !issue_ready ##1 issue_ready) else $error("peripheral stall wrong");
  c_taken: cover property (branch_taken);
  c_periph: cover property (go && periph_access);
  c_carry_add: cover property (go && opcode == `OP_ADD_CARRY);
endmodule
bind cpu_arith_branch_subset cpu_arith_branch_subset_asserts cpu_arith_branch_subset_asserts_i (.*);

// ==== sim/acc_file.sv ====
`timescale 1ns/1ns
module acc_file #(
  parameter [39:0] A_INIT = 40'h0000000100,
  parameter [39:0] B_INIT = 40'h0000000200
) (
  input wire clk,
  input wire reset_n,
  input wire acc_result_valid,
  input wire acc_result_sel,
  input wire [39:0] acc_result,
  output reg [39:0] acc_a_in,
  output reg [39:0] acc_b_in
);
  // writeback lands one cycle after the result pulse
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_a_in <= A_INIT;
      acc_b_in <= B_INIT;
    end else if (acc_result_valid && !acc_result_sel) begin
      acc_a_in <= acc_result;
    end else if (acc_result_valid) begin
      acc_b_in <= acc_result;
    end
  end
endmodule

// ==== sim/cpu_arith_branch_subset_bench.sv ====
`timescale 1ns/1ns
`include "alu_defines.vh"
`define CHK(nm, got, exp) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module cpu_arith_branch_subset_bench;
  reg clk = 0, reset_n = 0, issue_valid = 0, acc_sel = 0, periph_access = 0;
  reg [3:0] opcode = 0;
  reg [4:0] cond = 0;
  reg [15:0] operand_a = 0, operand_b = 0;
  wire [39:0] acc_a_in, acc_b_in, acc_result;
  wire [15:0] result;
  wire issue_ready, result_valid, acc_result_valid, acc_result_sel, branch_taken, flush;
  wire carry_flag, half_carry_flag, negative_flag, overflow_flag, zero_flag;
  wire acc_a_overflow_flag, acc_b_overflow_flag, acc_a_saturated_flag, acc_b_saturated_flag;
  integer failures = 0, cmp_count = 0, cycles = 0, i, w;
  // taken pattern per condition code with carry and half carry set, all other flags clear
  localparam [20:0] taken_map = 21'h10381f;
  cpu_arith_branch_subset cpu_arith_branch_subset_i (.*);
  // accumulator b starts near the top so that both adds overflow and the first one saturates
  acc_file #(.B_INIT(40'h7fffffff00)) acc_file_i (.*);
  initial begin
    forever #20 clk = ~clk;
  end
  task report_and_stop;
    begin
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures++;
      report_and_stop;
    end
  end
  // entered at a falling edge, leaves at the falling edge after acceptance
  task iss(input [3:0] op, input [4:0] cc, input [15:0] a, input [15:0] b, input p);
    begin
      issue_valid = 1;
      opcode = op;
      cond = cc;
      operand_a = a;
      operand_b = b;
      periph_access = p;
      w = 0;
      while (issue_ready !== 1'b1 && w < 10) begin
        @(negedge clk);
        w++;
      end
      @(posedge clk);
      @(negedge clk);
    end
  endtask
  initial begin
    repeat (4) @(negedge clk);
    reset_n = 1;
    @(negedge clk);
    iss(`OP_ADD_CARRY, 0, 16'hffff, 16'h0001, 0);
    `CHK("carry_add1", {result_valid, carry_flag, half_carry_flag, result}, 19'h70000)
    iss(`OP_ADD_CARRY, 0, 16'h0001, 16'h0002, 0);
    `CHK("carry_add2", {result_valid, carry_flag, half_carry_flag, result}, 19'h40004)
    iss(`OP_ADD_CARRY, 0, 16'h7fff, 16'h0001, 0);
    `CHK("carry_add3", {carry_flag, negative_flag, overflow_flag, result}, 19'h38000)
    // amount wider than four bits is masked
    iss(`OP_SHR_REG, 0, 16'h8000, 16'h0013, 0);
    `CHK("shr_reg", {carry_flag, overflow_flag, negative_flag, result}, 19'h3f000)
    iss(`OP_SHR_ONE, 0, 16'h0003, 16'h0000, 0);
    `CHK("shr_one", {carry_flag, overflow_flag, negative_flag, zero_flag, result}, 20'h80001)
    for (i = 0; i <= 20; i++) begin
      iss(`OP_BRANCH, i[4:0], 16'h0000, 16'h0000, 0);
      `CHK("branch", {branch_taken, carry_flag, overflow_flag}, {taken_map[i], 2'b10})
    end
    iss(`OP_OTHER, 0, 16'h0000, 16'h0000, 1);
    `CHK("periph", issue_ready, 1'b0)
    iss(`OP_ADD_ACCS, 0, 16'h0000, 16'h0000, 0);
    `CHK("acc_add", {acc_result_valid, carry_flag, acc_result}, {2'b11, 40'h7fffffffff})
    `CHK("acc_a_flags", {acc_a_overflow_flag, acc_a_saturated_flag}, 2'b11)
    `CHK("acc_b_clear", {acc_b_overflow_flag, acc_b_saturated_flag}, 2'b00)
    iss(`OP_BRANCH, `CC_ACC_A_SAT, 16'h0000, 16'h0000, 0);
    `CHK("branch_sat", branch_taken, 1'b1)
    iss(`OP_BRANCH, `CC_ACC_B_OVF, 16'h0000, 16'h0000, 0);
    `CHK("branch_ovf", branch_taken, 1'b0)
    acc_sel = 1;
    iss(`OP_ADD_ACC, 0, 16'h0001, 16'h0000, 0);
    `CHK("acc_b", {acc_result_sel, acc_b_overflow_flag, acc_b_saturated_flag, acc_result}, {3'b110, 40'h7fffffff01})
    issue_valid = 0;
    repeat (3) @(negedge clk);
    report_and_stop;
  end
endmodule
